// file: logic/carkit_latch_and_vendor_regs.sv
// Purpose: Carkit event latches, squelch and drive trims, charger detection control over ULPI
// Assumes: ULPI link is synchronous to ref_clk_i; analog status inputs are asynchronous
// Notes:   Interrupt enables and conversion start come from neighbouring register logic
//          Every output is taken from the state register
//
// Summary of operation
// [R1] Latch register reads then clears itself
// [R2] Bit 0 on ID going floating
// [R3] Bit 0 also on ID leaving floating
// [R4] Bit 1 on comparator change, either way
// [R5] Bit 3 on conversion-done rising edge
// [R6] Latch bits 2 and 7:4 read zero
// [R7] Vendor range answers immediate read/write
// [R8] Compensation bits 1:0 squelch threshold
// [R9] Compensation bits 6:4 transmit amplitude
// [R10] Charger bits 0..2 enables, reset zero
// [R11] Bit 3 swaps DP and DM connections
// [R12] Bit 4 comparator, SE0 and enabled
// [R13] Comparator forced zero while sink off
// [R14] Link clears detection before USB use
// [R15] Conversion done set after 282 us
// [R16] Event during latch read kept
`timescale 1ns/10ps

module carkit_latch_and_vendor_regs #(
    parameter int RID_CONV_CYCLES = carkit_vendor_pkg::RID_CONV_CYCLES_DEF
) (
    // Clock and reset
    input  wire logic       ref_clk_i,
    input  wire logic       reset_i,
    // ULPI register access
    input  wire logic [7:0] ulpi_data_i,
    input  wire logic       ulpi_stp_i,
    output logic      [7:0] ulpi_data_o,
    output logic            ulpi_data_oe_o,
    output logic            ulpi_dir_o,
    output logic            ulpi_nxt_o,
    // Interrupt enables
    input  wire logic       id_to_floating_irq_en_i,
    input  wire logic       id_to_grounded_irq_en_i,
    input  wire logic       contact_cmp_irq_en_i,
    input  wire logic       rid_done_irq_en_i,
    // Asynchronous analog status
    input  wire logic       id_float_i,
    input  wire logic       dp_cmp_i,
    input  wire logic       dm_cmp_i,
    // Same-domain status and control
    input  wire logic [1:0] linestate_i,
    input  wire logic       rid_conv_start_i,
    input  wire logic       rid_done_clear_i,
    // Trim outputs
    output logic      [1:0] squelch_threshold_sel_o,
    output logic      [2:0] hs_drive_level_sel_o,
    // Charger detection control
    output logic            data_vsource_en_o,
    output logic            data_isink_cmp_en_o,
    output logic            contact_current_en_o,
    output logic            charging_host_role_o,
    output logic            dp_vsource_en_o,
    output logic            dm_vsource_en_o,
    output logic            dp_isink_en_o,
    output logic            dm_isink_en_o,
    output logic            dp_contact_src_en_o,
    output logic            dm_contact_src_en_o,
    // Status outputs
    output logic            contact_cmp_out_o,
    output logic            rid_conv_busy_o,
    output logic            rid_conv_complete_o,
    output logic      [2:0] event_latch_o,
    output logic            event_pending_o
);

    // Count loaded at start; zero is the last busy cycle
    localparam logic [carkit_vendor_pkg::RID_CNT_W-1:0] RID_LOAD =
        carkit_vendor_pkg::RID_CNT_W'(RID_CONV_CYCLES - 1);

    carkit_vendor_pkg::regs_t r;
    carkit_vendor_pkg::regs_t next_r;

    // Read value for a register address
    function automatic logic [7:0] reg_read(input logic [5:0]               a,
                                            input carkit_vendor_pkg::regs_t s);
        logic [7:0] v;
        v = 8'h00;
        if (a == carkit_vendor_pkg::ADDR_LATCH) begin
            // [R6] Unused bits zero
            v[carkit_vendor_pkg::LATCH_ID_BIT]  = s.latch.id;
            v[carkit_vendor_pkg::LATCH_CMP_BIT] = s.latch.cmp;
            v[carkit_vendor_pkg::LATCH_RID_BIT] = s.latch.rid;
        end else if (a == carkit_vendor_pkg::ADDR_COMP) begin
            // [R9] Reserved bits zero
            v[carkit_vendor_pkg::SQ_MSB:carkit_vendor_pkg::SQ_LSB]   = s.comp.sq;
            v[carkit_vendor_pkg::DRV_MSB:carkit_vendor_pkg::DRV_LSB] = s.comp.drv;
        end else if (a == carkit_vendor_pkg::ADDR_CHG) begin
            // [R10] [R12] Enables, role and comparator
            v[carkit_vendor_pkg::CHG_VSRC_BIT]    = s.chg.vsrc;
            v[carkit_vendor_pkg::CHG_ISINK_BIT]   = s.chg.isink;
            v[carkit_vendor_pkg::CHG_CONTACT_BIT] = s.chg.contact;
            v[carkit_vendor_pkg::CHG_ROLE_BIT]    = s.chg.role;
            v[carkit_vendor_pkg::CHG_CMP_BIT]     = s.cmp;
        end
        return v;
    endfunction

    // Next-state logic
    always_comb begin
        logic                 wr_commit;
        logic                 rd_clear;
        logic                 sense;
        logic                 ev_id;
        logic                 ev_cmp;
        logic                 ev_rid;
        logic                 rid_finish;
        carkit_vendor_pkg::latch_t base;
        wr_commit  = 1'b0;
        rd_clear   = 1'b0;
        sense      = 1'b0;
        ev_id      = 1'b0;
        ev_cmp     = 1'b0;
        ev_rid     = 1'b0;
        rid_finish = 1'b0;
        base       = '0;
        next_r     = r;

        // Three-stage sync; a change counts once stages two and three agree
        next_r.sy1 = {dm_cmp_i, dp_cmp_i, id_float_i};
        next_r.sy2 = r.sy1;
        next_r.sy3 = r.sy2;
        for (int i = 0; i < carkit_vendor_pkg::SYN_N; i++) begin
            if (r.sy2[i] == r.sy3[i]) begin
                next_r.stable[i] = r.sy3[i];
            end
        end

        // [R7] Immediate register read and write sequencer
        next_r.bus.nxt = 1'b0;
        unique case (r.ust)
            carkit_vendor_pkg::U_IDLE: begin
                // Commands are only looked at while idle
                next_r.bus.dir  = 1'b0;
                next_r.bus.oe   = 1'b0;
                next_r.bus.dout = 8'h00;
                if (ulpi_data_i[7:6] == carkit_vendor_pkg::CMD_REG_WR) begin
                    next_r.addr    = ulpi_data_i[5:0];
                    next_r.bus.nxt = 1'b1;
                    next_r.ust     = carkit_vendor_pkg::U_WR_ACK;
                end else if (ulpi_data_i[7:6] == carkit_vendor_pkg::CMD_REG_RD) begin
                    next_r.addr    = ulpi_data_i[5:0];
                    next_r.bus.nxt = 1'b1;
                    next_r.ust     = carkit_vendor_pkg::U_RD_ACK;
                end
            end
            carkit_vendor_pkg::U_WR_ACK: begin
                next_r.ust = carkit_vendor_pkg::U_WR_DATA;
            end
            carkit_vendor_pkg::U_WR_DATA: begin
                next_r.wdata   = ulpi_data_i;
                next_r.bus.nxt = 1'b1;
                next_r.ust     = carkit_vendor_pkg::U_WR_STOP;
            end
            carkit_vendor_pkg::U_WR_STOP: begin
                // Commit waits for stop; data already held
                if (ulpi_stp_i) begin
                    wr_commit  = 1'b1;
                    next_r.ust = carkit_vendor_pkg::U_IDLE;
                end
            end
            carkit_vendor_pkg::U_RD_ACK: begin
                next_r.bus.dir = 1'b1; // Turnaround, nobody drives
                next_r.ust     = carkit_vendor_pkg::U_RD_TURN;
            end
            carkit_vendor_pkg::U_RD_TURN: begin
                // Data byte loaded and latch cleared on this edge
                next_r.bus.oe   = 1'b1;
                next_r.bus.dout = reg_read(r.addr, r);
                rd_clear        = (r.addr == carkit_vendor_pkg::ADDR_LATCH);
                next_r.ust      = carkit_vendor_pkg::U_RD_DATA;
            end
            carkit_vendor_pkg::U_RD_DATA: begin
                // Hand the bus back to the link
                next_r.bus.dir  = 1'b0;
                next_r.bus.oe   = 1'b0;
                next_r.bus.dout = 8'h00;
                next_r.ust      = carkit_vendor_pkg::U_IDLE;
            end
            default: begin
                next_r.bus = '0;
                next_r.ust = carkit_vendor_pkg::U_IDLE;
            end
        endcase

        // Register writes; read-only and unmapped bits ignored
        if (wr_commit) begin
            if (r.addr == carkit_vendor_pkg::ADDR_COMP) begin
                // [R8] Squelch threshold code
                next_r.comp.sq  = r.wdata[carkit_vendor_pkg::SQ_MSB:carkit_vendor_pkg::SQ_LSB];
                // [R9] Transmit amplitude code
                next_r.comp.drv = r.wdata[carkit_vendor_pkg::DRV_MSB:carkit_vendor_pkg::DRV_LSB];
            end else if (r.addr == carkit_vendor_pkg::ADDR_CHG) begin
                // [R10] Detection enables
                next_r.chg.vsrc    = r.wdata[carkit_vendor_pkg::CHG_VSRC_BIT];
                next_r.chg.isink   = r.wdata[carkit_vendor_pkg::CHG_ISINK_BIT];
                next_r.chg.contact = r.wdata[carkit_vendor_pkg::CHG_CONTACT_BIT];
                next_r.chg.role    = r.wdata[carkit_vendor_pkg::CHG_ROLE_BIT];
            end
        end

        // [R11] Route enables to DP or DM by role
        next_r.pads.dp_vsrc    = next_r.chg.vsrc & ~next_r.chg.role;
        next_r.pads.dm_vsrc    = next_r.chg.vsrc & next_r.chg.role;
        next_r.pads.dp_isink   = next_r.chg.isink & ~next_r.chg.role;
        next_r.pads.dm_isink   = next_r.chg.isink & next_r.chg.role;
        next_r.pads.dp_contact = next_r.chg.contact & ~next_r.chg.role;
        next_r.pads.dm_contact = next_r.chg.contact & next_r.chg.role;

        // [R11] Comparator senses the swapped line in host role
        // Role and enable taken from next state so the comparator
        // drops on the very edge that clears the sink enable
        sense = next_r.chg.role ? r.stable[carkit_vendor_pkg::SYN_DM]
                                : r.stable[carkit_vendor_pkg::SYN_DP];
        // [R12] [R13] Comparator qualified by enable and SE0
        next_r.cmp = next_r.chg.isink & sense
                   & (linestate_i == carkit_vendor_pkg::LS_SE0);

        // [R15] Conversion timer
        // Start pulses ignored while busy
        if (r.rid_busy) begin
            if (r.rid_cnt == '0) begin
                rid_finish      = 1'b1;
                next_r.rid_busy = 1'b0;
            end else begin
                next_r.rid_cnt = r.rid_cnt - 1'b1;
            end
        end else if (rid_conv_start_i) begin
            next_r.rid_busy = 1'b1;
            next_r.rid_cnt  = RID_LOAD;
        end
        // Completion set wins over clear
        if (rid_done_clear_i) begin
            next_r.rid_done = 1'b0;
        end
        if (rid_finish) begin
            next_r.rid_done = 1'b1;
        end

        // [R2] [R3] ID float edges in both directions
        ev_id = (next_r.stable[carkit_vendor_pkg::SYN_ID] & ~r.stable[carkit_vendor_pkg::SYN_ID]
                 & id_to_floating_irq_en_i)
              | (~next_r.stable[carkit_vendor_pkg::SYN_ID] & r.stable[carkit_vendor_pkg::SYN_ID]
                 & id_to_grounded_irq_en_i);
        // [R4] Comparator change either way
        ev_cmp = (next_r.cmp != r.cmp) & contact_cmp_irq_en_i;
        // [R5] Conversion-done rising edge only
        ev_rid = next_r.rid_done & ~r.rid_done & rid_done_irq_en_i;

        // [R1] Read clears latches
        base = rd_clear ? '0 : r.latch;
        // [R16] New event survives the clearing read
        next_r.latch.id  = base.id | ev_id;
        next_r.latch.cmp = base.cmp | ev_cmp;
        next_r.latch.rid = base.rid | ev_rid;
        // Pending flag kept in a flop beside the latches
        next_r.pend = next_r.latch.id | next_r.latch.cmp | next_r.latch.rid;
    end

    // State register
    // Asynchronous reset returns every field to zero
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            r <= carkit_vendor_pkg::REGS_RST;
        end else begin
            r <= next_r;
        end
    end

    // ULPI outputs
    assign ulpi_data_o    = r.bus.dout;
    assign ulpi_data_oe_o = r.bus.oe;
    assign ulpi_dir_o     = r.bus.dir;
    assign ulpi_nxt_o     = r.bus.nxt;

    // Trim and detection outputs
    assign squelch_threshold_sel_o = r.comp.sq;
    assign hs_drive_level_sel_o    = r.comp.drv;
    assign data_vsource_en_o       = r.chg.vsrc;
    assign data_isink_cmp_en_o     = r.chg.isink;
    assign contact_current_en_o    = r.chg.contact;
    assign charging_host_role_o    = r.chg.role;
    assign dp_vsource_en_o         = r.pads.dp_vsrc;
    assign dm_vsource_en_o         = r.pads.dm_vsrc;
    assign dp_isink_en_o           = r.pads.dp_isink;
    assign dm_isink_en_o           = r.pads.dm_isink;
    assign dp_contact_src_en_o     = r.pads.dp_contact;
    assign dm_contact_src_en_o     = r.pads.dm_contact;

    // Status outputs
    assign contact_cmp_out_o   = r.cmp;
    assign rid_conv_busy_o     = r.rid_busy;
    assign rid_conv_complete_o = r.rid_done;
    assign event_latch_o       = r.latch;
    assign event_pending_o     = r.pend;

endmodule

// file: logic/carkit_vendor_pkg.sv
// Purpose: Shared constants and types for the carkit latch and vendor register block
// Assumes: ULPI clock of 25 MHz drives all logic
// Notes:   Register addresses are the 6-bit ULPI immediate register addresses
package carkit_vendor_pkg;

    // Clock and conversion timing
    localparam int CLK_PERIOD_NS       = 40;
    localparam int RID_CONV_TIME_NS    = 282000;
    localparam int RID_CONV_CYCLES_DEF = (RID_CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RID_CNT_W           = 16;

    // Register addresses
    localparam logic [5:0] ADDR_LATCH = 6'h21;
    localparam logic [5:0] ADDR_COMP  = 6'h31;
    localparam logic [5:0] ADDR_CHG   = 6'h32;

    // Transmit command codes in data[7:6]
    localparam logic [1:0] CMD_REG_WR = 2'h2;
    localparam logic [1:0] CMD_REG_RD = 2'h3;

    // Latch register bit positions
    localparam int LATCH_ID_BIT  = 0;
    localparam int LATCH_CMP_BIT = 1;
    localparam int LATCH_RID_BIT = 3;

    // Compensation register fields
    localparam int SQ_LSB  = 0;
    localparam int SQ_MSB  = 1;
    localparam int DRV_LSB = 4;
    localparam int DRV_MSB = 6;

    // Charger detection register bits
    localparam int CHG_VSRC_BIT    = 0;
    localparam int CHG_ISINK_BIT   = 1;
    localparam int CHG_CONTACT_BIT = 2;
    localparam int CHG_ROLE_BIT    = 3;
    localparam int CHG_CMP_BIT     = 4;

    // Line state that allows the comparator result
    localparam logic [1:0] LS_SE0 = 2'h0;

    // Asynchronous input indexes
    localparam int SYN_N  = 3;
    localparam int SYN_ID = 0;
    localparam int SYN_DP = 1;
    localparam int SYN_DM = 2;

    // Register access sequencer
    typedef enum logic [2:0] {
        U_IDLE    = 3'h0,
        U_WR_ACK  = 3'h1,
        U_WR_DATA = 3'h2,
        U_WR_STOP = 3'h3,
        U_RD_ACK  = 3'h4,
        U_RD_TURN = 3'h5,
        U_RD_DATA = 3'h6
    } ulpi_state_t;

    typedef struct packed {
        logic       dir;
        logic       nxt;
        logic       oe;
        logic [7:0] dout;
    } ulpi_out_t;

    typedef struct packed {
        logic [2:0] drv;
        logic [1:0] sq;
    } comp_t;

    typedef struct packed {
        logic role;
        logic contact;
        logic isink;
        logic vsrc;
    } chg_t;

    typedef struct packed {
        logic dp_vsrc;
        logic dm_vsrc;
        logic dp_isink;
        logic dm_isink;
        logic dp_contact;
        logic dm_contact;
    } pad_drive_t;

    typedef struct packed {
        logic rid;
        logic cmp;
        logic id;
    } latch_t;

    typedef struct packed {
        ulpi_state_t          ust;
        logic [5:0]           addr;
        logic [7:0]           wdata;
        ulpi_out_t            bus;
        comp_t                comp;
        chg_t                 chg;
        pad_drive_t           pads;
        logic [SYN_N-1:0]     sy1;
        logic [SYN_N-1:0]     sy2;
        logic [SYN_N-1:0]     sy3;
        logic [SYN_N-1:0]     stable;
        logic                 cmp;
        latch_t               latch;
        logic                 rid_busy;
        logic [RID_CNT_W-1:0] rid_cnt;
        logic                 rid_done;
        logic                 pend;
    } regs_t;

    // Reset values: all codes nominal, all enables off, sequencer idle
    localparam comp_t COMP_RST = '0;
    localparam chg_t  CHG_RST  = '0;
    localparam regs_t REGS_RST = '0;

endpackage

// file: test/carkit_regs_chk.sv
// Purpose: Port assertions for the carkit latch and vendor registers
// Assumes: One clock domain, asynchronous active-high reset
// Notes:   Read address is tracked from the command byte seen with nxt
`timescale 1ns/10ps
module carkit_regs_chk #(
    parameter int RID_CONV_CYCLES = 8
) (
    // Clock, reset and bus
    input wire logic       ref_clk_i,
    input wire logic       reset_i,
    input wire logic [7:0] ulpi_data_i,
    input wire logic [7:0] ulpi_data_o,
    input wire logic       ulpi_data_oe_o,
    input wire logic       ulpi_dir_o,
    input wire logic       ulpi_nxt_o,
    // Controls and status
    input wire logic       contact_cmp_irq_en_i,
    input wire logic       rid_done_irq_en_i,
    input wire logic [1:0] linestate_i,
    input wire logic       rid_conv_start_i,
    input wire logic [1:0] squelch_threshold_sel_o,
    input wire logic [2:0] hs_drive_level_sel_o,
    input wire logic       data_vsource_en_o,
    input wire logic       data_isink_cmp_en_o,
    input wire logic       contact_current_en_o,
    input wire logic       charging_host_role_o,
    input wire logic       contact_cmp_out_o,
    input wire logic       rid_conv_busy_o,
    input wire logic       rid_conv_complete_o,
    input wire logic [2:0] event_latch_o
);
    localparam int RID_GAP = RID_CONV_CYCLES;
    logic       wr_ph;
    logic       rd_cmd;
    logic [5:0] rd_addr;
    // Read command seen in its nxt cycle
    assign rd_cmd = ulpi_nxt_o && !wr_ph && !ulpi_dir_o && ulpi_data_i[7:6] == carkit_vendor_pkg::CMD_REG_RD;
    // Write phase and read address trackers
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            wr_ph   <= 1'b0;
            rd_addr <= 6'h00;
        end else if (ulpi_nxt_o) begin
            wr_ph <= !wr_ph && ulpi_data_i[7:6] == carkit_vendor_pkg::CMD_REG_WR;
            if (rd_cmd) begin
                rd_addr <= ulpi_data_i[5:0];
            end
        end
    end
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    // Read and conversion steps
    sequence s_turn; ulpi_dir_o && !ulpi_data_oe_o && !ulpi_nxt_o; endsequence
    sequence s_data; ulpi_dir_o && ulpi_data_oe_o; endsequence
    sequence s_conv; rid_conv_busy_o ##RID_GAP $rose(rid_conv_complete_o); endsequence
    AST_RD_WALK: assert property (rd_cmd |=> s_turn ##1 s_data ##1 !ulpi_dir_o)
        else $error("read walk out of step");
    AST_LATCH_DATA: assert property (s_data and rd_addr == carkit_vendor_pkg::ADDR_LATCH
        |-> ulpi_data_o == {4'h0, $past(event_latch_o[2]), 1'b0, $past(event_latch_o[1:0])})
        else $error("latch read data wrong");
    AST_COMP_DATA: assert property (s_data and rd_addr == carkit_vendor_pkg::ADDR_COMP
        |-> ulpi_data_o == {1'b0, hs_drive_level_sel_o, 2'h0, squelch_threshold_sel_o})
        else $error("trim read data wrong");
    AST_CHG_DATA: assert property (s_data and rd_addr == carkit_vendor_pkg::ADDR_CHG
        |-> ulpi_data_o == {3'h0, $past(contact_cmp_out_o), charging_host_role_o, contact_current_en_o,
        data_isink_cmp_en_o, data_vsource_en_o}) else $error("charger read data wrong");
    AST_CMP_OFF: assert property (!data_isink_cmp_en_o |-> !contact_cmp_out_o)
        else $error("comparator high while sink off");
    AST_CMP_LS: assert property (linestate_i != carkit_vendor_pkg::LS_SE0 |=> !contact_cmp_out_o)
        else $error("comparator high outside SE0");
    AST_RID_TIME: assert property (rid_conv_start_i && !rid_conv_busy_o && !rid_conv_complete_o
        |=> s_conv) else $error("conversion time wrong");
    AST_RID_LATCH: assert property ($rose(rid_conv_complete_o) && rid_done_irq_en_i |-> event_latch_o[2])
        else $error("conversion latch missed");
    AST_CMP_LATCH: assert property ($changed(contact_cmp_out_o) && contact_cmp_irq_en_i
        |-> event_latch_o[1]) else $error("comparator latch missed");
endmodule

// file: test/ulpi_link_model.sv
// Purpose: Link side issuing ULPI immediate register accesses
// Assumes: Link owns the data lines while dir is low
// Notes:   Idle data is 00h; lost handshakes are counted in misses
`timescale 1ns/10ps
module ulpi_link_model (
    // Clock and bus from block
    input  wire logic       clk_i,
    input  wire logic       dir_i,
    input  wire logic       nxt_i,
    input  wire logic       oe_i,
    input  wire logic [7:0] data_i,
    // Bus to block
    output logic      [7:0] data_o,
    output logic            stp_o
);
    int misses = 0;
    initial begin
        data_o = 8'h00;
        stp_o  = 1'b0;
    end
    // Hold until nxt is sampled high, bounded
    task automatic wait_nxt();
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (!nxt_i && n < 20);
        if (!nxt_i) misses++;
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk_i);
        data_o <= {carkit_vendor_pkg::CMD_REG_WR, a};
        wait_nxt();
        data_o <= d;
        wait_nxt();
        data_o <= 8'h00;
        stp_o  <= 1'b1;
        @(posedge clk_i);
        stp_o <= 1'b0;
    endtask
    // immediate read, data taken in its one cycle
    task automatic rd(input logic [5:0] a, output logic [7:0] v);
        @(posedge clk_i);
        data_o <= {carkit_vendor_pkg::CMD_REG_RD, a};
        wait_nxt();
        data_o <= 8'h00;
        repeat (2) @(posedge clk_i);
        if (!(dir_i && oe_i)) misses++;
        v = data_i;
    endtask
endmodule

// file: test/tb.sv
// Purpose: Self-checking bench for the carkit latch and vendor registers
// Assumes: All register traffic goes through the link model
// Notes:   A short conversion count keeps the run brief
`timescale 1ns/10ps
module tb;
    localparam int NCONV = 8;
    typedef struct packed {
        logic [5:0] a;
        logic [7:0] d;
        logic [7:0] e;
    } row_t;
    // Address, write value, expected read-back
    localparam row_t ROWS [7] = '{'{6'h21, 8'hff, 8'h00}, '{6'h31, 8'hff, 8'h73}, '{6'h31, 8'ha6, 8'h22},
        '{6'h32, 8'hf7, 8'h07}, '{6'h32, 8'h00, 8'h00}, '{6'h3f, 8'hff, 8'h00}, '{6'h30, 8'h5a, 8'h00}};
    logic       clk, rst, stp, oe, dir, nxt, busy, done, pend, cmp;
    logic       en_fl, en_gr, en_cmp, en_rid, idf, dpc, dmc, start, dclr;
    logic [7:0] din, dout, v;
    logic [1:0] ls, sq;
    logic [2:0] drv, lat;
    logic [3:0] chg;
    logic [5:0] pads;
    int         failures = 0;
    int         total_checks = 0;
    int         cyc = 0;
    carkit_latch_and_vendor_regs #(.RID_CONV_CYCLES(NCONV)) uut (
        .ref_clk_i(clk), .reset_i(rst), .ulpi_data_i(din), .ulpi_stp_i(stp), .ulpi_data_o(dout),
        .ulpi_data_oe_o(oe), .ulpi_dir_o(dir), .ulpi_nxt_o(nxt), .id_to_floating_irq_en_i(en_fl),
        .id_to_grounded_irq_en_i(en_gr), .contact_cmp_irq_en_i(en_cmp), .rid_done_irq_en_i(en_rid),
        .id_float_i(idf), .dp_cmp_i(dpc), .dm_cmp_i(dmc), .linestate_i(ls), .rid_conv_start_i(start),
        .rid_done_clear_i(dclr), .squelch_threshold_sel_o(sq), .hs_drive_level_sel_o(drv),
        .data_vsource_en_o(chg[0]), .data_isink_cmp_en_o(chg[1]), .contact_current_en_o(chg[2]),
        .charging_host_role_o(chg[3]), .dp_vsource_en_o(pads[5]), .dm_vsource_en_o(pads[4]),
        .dp_isink_en_o(pads[3]), .dm_isink_en_o(pads[2]), .dp_contact_src_en_o(pads[1]),
        .dm_contact_src_en_o(pads[0]), .contact_cmp_out_o(cmp), .rid_conv_busy_o(busy),
        .rid_conv_complete_o(done), .event_latch_o(lat), .event_pending_o(pend));
    ulpi_link_model link (.clk_i(clk), .dir_i(dir), .nxt_i(nxt), .oe_i(oe), .data_i(dout), .data_o(din),
        .stp_o(stp));
    // Clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks=%0d failures=%0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Cycle ceiling against a hang
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            failures++;
            finish_test();
        end
    end
    // Main sequence
    initial begin
        {rst, en_fl, en_gr, en_cmp, en_rid, idf, dpc, dmc, start, dclr} = 10'h200;
        ls = 2'h1;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        foreach (ROWS[i]) begin
            link.wr(ROWS[i].a, ROWS[i].d);
            link.rd(ROWS[i].a, v);
            check(v, ROWS[i].e);
        end
        link.wr(carkit_vendor_pkg::ADDR_COMP, 8'h53);
        // Reset in mid-run returns all fields to zero
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        check({dir, nxt, oe, sq, drv}, 8'h00);
        rst <= 1'b0;
        link.rd(carkit_vendor_pkg::ADDR_COMP, v);
        check(v, 8'h00);
        for (int i = 0; i < 8; i++) begin
            link.wr(carkit_vendor_pkg::ADDR_COMP, {1'b0, 3'(i), 2'h0, 2'(i)});
            @(posedge clk);
            check({drv, sq}, {3'(i), 2'(i)});
        end
        link.wr(carkit_vendor_pkg::ADDR_CHG, 8'h07);
        @(posedge clk);
        check(pads, 6'h2a);
        link.wr(carkit_vendor_pkg::ADDR_CHG, 8'h0f);
        @(posedge clk);
        check(pads, 6'h15);
        en_cmp <= 1'b1;
        ls <= 2'h0;
        dpc <= 1'b1;
        repeat (8) @(posedge clk);
        check(cmp, 1'b0);
        dmc <= 1'b1;
        repeat (8) @(posedge clk);
        check(cmp, 1'b1);
        link.rd(carkit_vendor_pkg::ADDR_CHG, v);
        check(v, 8'h1f);
        ls <= 2'h1;
        repeat (2) @(posedge clk);
        check(cmp, 1'b0);
        ls <= 2'h0;
        link.wr(carkit_vendor_pkg::ADDR_CHG, 8'h08);
        repeat (2) @(posedge clk);
        check(cmp, 1'b0);
        link.rd(carkit_vendor_pkg::ADDR_LATCH, v);
        check(v, 8'h02);
        check(lat, 3'h0);
        en_cmp <= 1'b0;
        en_fl <= 1'b1;
        idf <= 1'b1;
        repeat (8) @(posedge clk);
        link.rd(carkit_vendor_pkg::ADDR_LATCH, v);
        check(v, 8'h01);
        en_fl <= 1'b0;
        en_gr <= 1'b1;
        idf <= 1'b0;
        repeat (8) @(posedge clk);
        link.rd(carkit_vendor_pkg::ADDR_LATCH, v);
        check(v, 8'h01);
        idf <= 1'b1;
        repeat (8) @(posedge clk);
        link.rd(carkit_vendor_pkg::ADDR_LATCH, v);
        check(v, 8'h00);
        en_rid <= 1'b1;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        repeat (NCONV + 2) @(posedge clk);
        check(done, 1'b1);
        link.rd(carkit_vendor_pkg::ADDR_LATCH, v);
        check(v, 8'h08);
        // Conversion ends on the very edge that clears the latch
        dclr <= 1'b1;
        @(posedge clk);
        dclr <= 1'b0;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        repeat (NCONV - 4) @(posedge clk);
        link.rd(carkit_vendor_pkg::ADDR_LATCH, v);
        check(v, 8'h00);
        check(lat, 3'h4);
        check(pend, 1'b1);
        link.rd(carkit_vendor_pkg::ADDR_LATCH, v);
        check(v, 8'h08);
        check(pend, 1'b0);
        link.wr(carkit_vendor_pkg::ADDR_CHG, 8'h00);
        @(posedge clk);
        check(chg, 4'h0);
        check(8'(link.misses), 8'h00);
        finish_test();
    end
endmodule
bind carkit_latch_and_vendor_regs carkit_regs_chk #(.RID_CONV_CYCLES(RID_CONV_CYCLES)) chk (.*);
